// *** design/blltm_pkg.sv ***
//----------------------------------------------------------------------
// Behaviour
// [R1] Time gap between frames of one command
// [R2] Same timeout between bytes inside a frame
// [R3] Timeout expiry raises a system reset
// [R4] Host keeps within the frame/byte timeout
// [R5] Host waits out erase before continuing
// [R6] Host waits connection time before command code
// [R7] Sync byte answered with acknowledge byte
// [R8] Host spaces SPI bytes by minimum delay
// [R9] Host waits USB connection time after attach
// [R10] Crystal found by start-of-frame, retrying enumeration
// [R11] Byte done or frame start restarts timeout
//----------------------------------------------------------------------
package blltm_pkg;

    //------------------------------------------------------------------
    // Clock and timing
    //------------------------------------------------------------------
    localparam int unsigned CLK_KHZ         = 10000;   // 10 MHz system clock
    localparam int unsigned I2C_TIMEOUT_MS  = 1000;
    localparam int unsigned I2C_TIMEOUT_CYC = I2C_TIMEOUT_MS * CLK_KHZ;
    localparam int unsigned SOF_WAIT_MS     = 3;       // window for a first SOF
    localparam int unsigned SOF_WAIT_CYC    = SOF_WAIT_MS * CLK_KHZ;
    localparam int unsigned DETACH_MS       = 10;      // disconnect hold per retry
    localparam int unsigned DETACH_CYC      = DETACH_MS * CLK_KHZ;
    localparam int unsigned CNT_W           = 32;

    //------------------------------------------------------------------
    // SPI link bytes
    //------------------------------------------------------------------
    localparam logic [7:0] SPI_SYNC_BYTE = 8'hA5;
    localparam logic [7:0] SPI_ACK_BYTE  = 8'h79;
    localparam logic [7:0] SPI_IDLE_BYTE = 8'h00;
    localparam logic [2:0] SPI_LAST_BIT  = 3'h7;

    //------------------------------------------------------------------
    // Crystal candidates, tried in this order
    //------------------------------------------------------------------
    localparam logic [1:0] XTAL_25M    = 2'h0;
    localparam logic [1:0] XTAL_14M7   = 2'h1;
    localparam logic [1:0] XTAL_8M     = 2'h2;
    localparam logic [1:0] XTAL_LAST   = XTAL_8M;

    // USB enumeration states, Gray along the usual path
    typedef enum logic [1:0] {
        BLLTM_USB_IDLE   = 2'h0,
        BLLTM_USB_TRY    = 2'h1,
        BLLTM_USB_LOCKED = 2'h3,
        BLLTM_USB_DETACH = 2'h2
    } blltm_usb_e;

endpackage

// *** design/blltm_top.sv ***
`timescale 1ns/1ns
module blltm_top #(
    parameter int unsigned I2C_TIMEOUT = blltm_pkg::I2C_TIMEOUT_CYC,
    parameter int unsigned SOF_WAIT    = blltm_pkg::SOF_WAIT_CYC,
    parameter int unsigned DETACH      = blltm_pkg::DETACH_CYC
) (
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    // I2C command engine events (system clock)
    input  wire logic       I2C_CMD_START,
    input  wire logic       I2C_FRAME_START,
    input  wire logic       I2C_BYTE_DONE,
    input  wire logic       I2C_CMD_END,
    output logic            I2C_TIMER_RUN,
    output logic            SYS_RESET,
    // SPI link (pins in own clock domain; received byte, valid and sync flag on system clock)
    input  wire logic       SPI_SCK,
    input  wire logic       SPI_NSS_N,
    input  wire logic       SPI_MOSI,
    output logic            SPI_MISO,
    output logic            SPI_MISO_OE,
    output logic [7:0]      SPI_RX_DATA,
    output logic            SPI_RX_VALID,
    output logic            SPI_SYNCED,
    // USB connection
    input  wire logic       USB_ATTACH,
    input  wire logic       USB_SOF,
    output logic            USB_CONNECT,
    output logic [1:0]      XTAL_SEL,
    output logic            XTAL_LOCKED
);
    import blltm_pkg::*;

    //------------------------------------------------------------------
    // I2C inter-frame / inter-byte supervision
    //------------------------------------------------------------------
    logic [CNT_W-1:0] i2c_cnt_r;
    logic             i2c_run_r;
    logic             sys_rst_r;

    // Timer restarts on each byte or frame while it runs; expiry ends the command
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            i2c_run_r <= 1'b0;
            i2c_cnt_r <= '0;
        end else if (I2C_CMD_START || (i2c_run_r && (I2C_FRAME_START || I2C_BYTE_DONE))) begin
            i2c_run_r <= 1'b1;                                   // R1
            i2c_cnt_r <= '0;                                     // R11
        end else if (I2C_CMD_END) begin
            i2c_run_r <= 1'b0;
            i2c_cnt_r <= '0;
        end else if (i2c_run_r) begin
            if (i2c_cnt_r == I2C_TIMEOUT - 1) begin
                i2c_run_r <= 1'b0;
                i2c_cnt_r <= '0;
            end else begin
                i2c_cnt_r <= i2c_cnt_r + 1'b1;                   // R2
            end
        end
    end

    // One-cycle system reset pulse on expiry
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sys_rst_r <= 1'b0;
        end else begin
            sys_rst_r <= i2c_run_r && !I2C_CMD_START && !I2C_FRAME_START
                         && !I2C_BYTE_DONE && !I2C_CMD_END
                         && (i2c_cnt_r == I2C_TIMEOUT - 1);      // R3
        end
    end

    assign I2C_TIMER_RUN = i2c_run_r;
    assign SYS_RESET     = sys_rst_r;

    //------------------------------------------------------------------
    // SPI link domain: receive shifter and byte hand-off
    //------------------------------------------------------------------
    logic [2:0] l_bit_r;
    logic [6:0] l_rx_sh_r;
    logic [7:0] l_rx_hold_r;
    logic       l_rx_tgl_r;

    // Sample MOSI on rising SCK, whole bytes flip a toggle
    always_ff @(posedge SPI_SCK or negedge ARST_N) begin
        if (!ARST_N) begin
            l_bit_r     <= '0;
            l_rx_sh_r   <= '0;
            l_rx_hold_r <= '0;
            l_rx_tgl_r  <= 1'b0;
        end else if (SPI_NSS_N) begin
            l_bit_r <= '0;
        end else begin
            l_bit_r   <= l_bit_r + 3'h1;
            l_rx_sh_r <= {l_rx_sh_r[5:0], SPI_MOSI};
            if (l_bit_r == SPI_LAST_BIT) begin
                l_rx_hold_r <= {l_rx_sh_r, SPI_MOSI};
                l_rx_tgl_r  <= ~l_rx_tgl_r;
            end
        end
    end

    //------------------------------------------------------------------
    // SPI link domain: transmit shifter on falling SCK
    //------------------------------------------------------------------
    logic [7:0] l_tx_sh_r;
    logic       l_ack_s1_r;
    logic       l_ack_s2_r;
    logic       l_ack_done_r;
    logic       ack_tgl_r;

    // Acknowledge request toggle brought into link domain
    always_ff @(negedge SPI_SCK or negedge ARST_N) begin
        if (!ARST_N) begin
            l_ack_s1_r <= 1'b0;
            l_ack_s2_r <= 1'b0;
        end else begin
            l_ack_s1_r <= ack_tgl_r;
            l_ack_s2_r <= l_ack_s1_r;
        end
    end

    // Byte boundary loads acknowledge when one is owed
    always_ff @(negedge SPI_SCK or negedge ARST_N) begin
        if (!ARST_N) begin
            l_tx_sh_r    <= SPI_IDLE_BYTE;
            l_ack_done_r <= 1'b0;
        end else if (l_bit_r == '0) begin
            if (l_ack_s2_r != l_ack_done_r) begin
                l_tx_sh_r    <= SPI_ACK_BYTE;                    // R7
                l_ack_done_r <= l_ack_s2_r;
            end else begin
                l_tx_sh_r <= SPI_IDLE_BYTE;
            end
        end else begin
            l_tx_sh_r <= {l_tx_sh_r[6:0], 1'b0};
        end
    end

    assign SPI_MISO    = l_tx_sh_r[7];
    assign SPI_MISO_OE = !SPI_NSS_N;

    //------------------------------------------------------------------
    // System domain: received byte and sync detection
    //------------------------------------------------------------------
    logic       rx_s1_r;
    logic       rx_s2_r;
    logic       rx_s3_r;
    logic [7:0] rx_data_r;
    logic       rx_valid_r;
    logic       synced_r;

    // Toggle synchroniser, third flop for edge detect
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_s1_r <= 1'b0;
            rx_s2_r <= 1'b0;
            rx_s3_r <= 1'b0;
        end else begin
            rx_s1_r <= l_rx_tgl_r;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
        end
    end

    // Hold byte stays still until the next byte, so it is safe here
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_data_r  <= '0;
            rx_valid_r <= 1'b0;
            synced_r   <= 1'b0;
            ack_tgl_r  <= 1'b0;
        end else begin
            rx_valid_r <= rx_s2_r ^ rx_s3_r;
            if (rx_s2_r ^ rx_s3_r) begin
                rx_data_r <= l_rx_hold_r;
                if (l_rx_hold_r == SPI_SYNC_BYTE) begin
                    synced_r  <= 1'b1;
                    ack_tgl_r <= ~ack_tgl_r;                     // R7
                end
            end
        end
    end

    assign SPI_RX_DATA  = rx_data_r;
    assign SPI_RX_VALID = rx_valid_r;
    assign SPI_SYNCED   = synced_r;

    //------------------------------------------------------------------
    // USB connection with crystal search
    //------------------------------------------------------------------
    logic             att_s1_r;
    logic             att_s2_r;
    blltm_usb_e       usb_st_r;
    logic [CNT_W-1:0] usb_cnt_r;
    logic [1:0]       xtal_r;

    // Cable attach pin synchroniser
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            att_s1_r <= 1'b0;
            att_s2_r <= 1'b0;
        end else begin
            att_s1_r <= USB_ATTACH;
            att_s2_r <= att_s1_r;
        end
    end

    // Connect per candidate; no SOF in window means detach and retry
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            usb_st_r  <= BLLTM_USB_IDLE;
            usb_cnt_r <= '0;
            xtal_r    <= XTAL_25M;
        end else if (!att_s2_r) begin
            usb_st_r  <= BLLTM_USB_IDLE;
            usb_cnt_r <= '0;
            xtal_r    <= XTAL_25M;
        end else begin
            case (usb_st_r)
                BLLTM_USB_IDLE: begin
                    usb_st_r  <= BLLTM_USB_TRY;
                    usb_cnt_r <= '0;
                end
                BLLTM_USB_TRY: begin
                    if (USB_SOF) begin
                        usb_st_r <= BLLTM_USB_LOCKED;            // R10
                    end else if (usb_cnt_r == SOF_WAIT - 1) begin
                        usb_st_r  <= BLLTM_USB_DETACH;           // R10
                        usb_cnt_r <= '0;
                    end else begin
                        usb_cnt_r <= usb_cnt_r + 1'b1;
                    end
                end
                BLLTM_USB_DETACH: begin
                    if (usb_cnt_r == DETACH - 1) begin
                        usb_st_r  <= BLLTM_USB_TRY;
                        usb_cnt_r <= '0;
                        xtal_r    <= (xtal_r == XTAL_LAST) ? XTAL_25M
                                                           : xtal_r + 2'h1; // R10
                    end else begin
                        usb_cnt_r <= usb_cnt_r + 1'b1;
                    end
                end
                BLLTM_USB_LOCKED: begin
                    usb_cnt_r <= '0;
                end
                default: begin
                    usb_st_r  <= BLLTM_USB_IDLE;
                    usb_cnt_r <= '0;
                end
            endcase
        end
    end

    assign USB_CONNECT = (usb_st_r == BLLTM_USB_TRY) || (usb_st_r == BLLTM_USB_LOCKED);
    assign XTAL_SEL    = xtal_r;
    assign XTAL_LOCKED = (usb_st_r == BLLTM_USB_LOCKED);

endmodule

// *** bench/blltm_properties.sv ***
`timescale 1ns/1ns
module blltm_properties #(
    parameter int unsigned I2C_TIMEOUT = 50
) (
    input wire logic       CLK,
    input wire logic       ARST_N,
    input wire logic       I2C_CMD_START,
    input wire logic       I2C_FRAME_START,
    input wire logic       I2C_BYTE_DONE,
    input wire logic       I2C_TIMER_RUN,
    input wire logic       SYS_RESET,
    input wire logic [7:0] SPI_RX_DATA,
    input wire logic       SPI_RX_VALID,
    input wire logic       SPI_SYNCED,
    input wire logic       USB_SOF,
    input wire logic       USB_CONNECT,
    input wire logic       XTAL_LOCKED
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    logic        restart;
    logic [31:0] cnt_r;
    // Cycles since the last timer restart
    assign restart = I2C_CMD_START | (I2C_TIMER_RUN & (I2C_FRAME_START | I2C_BYTE_DONE));
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= restart ? 32'h0 : cnt_r + 32'h1;
        end
    end
    // Timer, link and crystal relations
    chk_start_arms: assert property (I2C_CMD_START |=> I2C_TIMER_RUN) else $error("no arm");
    chk_expiry_time: assert property (SYS_RESET |-> cnt_r == I2C_TIMEOUT) else $error("when");
    chk_reset_pulse: assert property (SYS_RESET |=> !SYS_RESET) else $error("long");
    chk_reset_stops: assert property (SYS_RESET |-> !I2C_TIMER_RUN) else $error("runs");
    chk_sync_flag: assert property (SPI_RX_VALID && SPI_RX_DATA == blltm_pkg::SPI_SYNC_BYTE |=> SPI_SYNCED) else $error("sync");
    chk_sync_held: assert property (SPI_SYNCED |=> SPI_SYNCED) else $error("lost");
    chk_sof_locks: assert property (USB_SOF && USB_CONNECT |=> XTAL_LOCKED) else $error("lock");
    chk_lock_conn: assert property (XTAL_LOCKED |-> USB_CONNECT) else $error("conn");
    cov_expiry: cover property (SYS_RESET);
    cov_synced: cover property (SPI_RX_VALID && SPI_SYNCED);
    cov_locked: cover property ($rose(XTAL_LOCKED));
endmodule

// *** bench/blltm_spi_host.sv ***
`timescale 1ns/1ns
module blltm_spi_host (
    output logic     sck,
    output logic     nss_n,
    output logic     mosi,
    input wire logic miso
);
    // Link clock stands low outside bytes
    initial begin
        sck = 1'b0;
        nss_n = 1'b1;
        mosi = 1'b0;
    end
    // Mode 0 byte, MSB first, 15 ns period
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        nss_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #7;
            sck = 1'b1;
            rx[i] = miso;
            #8;
            sck = 1'b0;
        end
        mosi = ~tx[0]; // No stale bit on line
        #8000;
    endtask
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import blltm_pkg::*;
    localparam int TO = 50;
    logic CLK = 1'b0, ARST_N = 1'b0, USB_ATTACH = 1'b0, USB_SOF = 1'b0;
    logic I2C_CMD_START = 1'b0, I2C_FRAME_START = 1'b0, I2C_BYTE_DONE = 1'b0, I2C_CMD_END = 1'b0;
    wire  SPI_SCK, SPI_NSS_N, SPI_MOSI, SPI_MISO, SPI_MISO_OE, SPI_RX_VALID, SPI_SYNCED;
    wire  I2C_TIMER_RUN, SYS_RESET, USB_CONNECT, XTAL_LOCKED;
    wire  [7:0] SPI_RX_DATA;
    wire  [1:0] XTAL_SEL;
    logic [7:0] tx, rx, expq[$];
    logic [3:0] fst [4] = '{4'h8, 4'h2, 4'h9, 4'h8};
    logic [3:0] snd [4] = '{4'h1, 4'h0, 4'h0, 4'h3};
    int         exq [4] = '{-1, -1, TO, TO};
    int         bad_count = 0;
    int         compares = 0;
    // Clock
    always #50 CLK = ~CLK;
    blltm_top #(
        .I2C_TIMEOUT (TO),
        .SOF_WAIT    (20),
        .DETACH      (10)
    ) u_dut (
        .CLK             (CLK),
        .ARST_N          (ARST_N),
        .I2C_CMD_START   (I2C_CMD_START),
        .I2C_FRAME_START (I2C_FRAME_START),
        .I2C_BYTE_DONE   (I2C_BYTE_DONE),
        .I2C_CMD_END     (I2C_CMD_END),
        .I2C_TIMER_RUN   (I2C_TIMER_RUN),
        .SYS_RESET       (SYS_RESET),
        .SPI_SCK         (SPI_SCK),
        .SPI_NSS_N       (SPI_NSS_N),
        .SPI_MOSI        (SPI_MOSI),
        .SPI_MISO        (SPI_MISO),
        .SPI_MISO_OE     (SPI_MISO_OE),
        .SPI_RX_DATA     (SPI_RX_DATA),
        .SPI_RX_VALID    (SPI_RX_VALID),
        .SPI_SYNCED      (SPI_SYNCED),
        .USB_ATTACH      (USB_ATTACH),
        .USB_SOF         (USB_SOF),
        .USB_CONNECT     (USB_CONNECT),
        .XTAL_SEL        (XTAL_SEL),
        .XTAL_LOCKED     (XTAL_LOCKED)
    );
    blltm_spi_host u_host (.sck(SPI_SCK), .nss_n(SPI_NSS_N), .mosi(SPI_MOSI), .miso(SPI_MISO));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic pulse(input logic [3:0] e);
        {I2C_CMD_START, I2C_FRAME_START, I2C_BYTE_DONE, I2C_CMD_END} <= e;
        @(posedge CLK);
        {I2C_CMD_START, I2C_FRAME_START, I2C_BYTE_DONE, I2C_CMD_END} <= 4'h0;
    endtask
    task automatic time_rst(input int exp);
        int n = -1;
        for (int i = 1; i <= 3 * TO; i++) begin
            @(posedge CLK);
            #1;
            if (SYS_RESET === 1'b1) begin
                n = i;
                break;
            end
        end
        check(n, exp);
    endtask
    task automatic wait_conn(input logic v);
        for (int i = 0; i < 200; i++) begin
            @(negedge CLK);
            if (USB_CONNECT === v) return;
        end
        check(USB_CONNECT, v);
        end_of_test();
    endtask
    // Received bytes against sent queue
    always @(negedge CLK) begin
        if (SPI_RX_VALID === 1'b1) check(SPI_RX_DATA, expq.pop_front());
    end
    // Hang guard
    initial begin
        #3000000;
        bad_count++;
        end_of_test();
    end
    // Main sequence
    initial begin
        void'($urandom(76292));
        repeat (5) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        pulse(4'h8);
        #1;
        check(I2C_TIMER_RUN, 1'b1);
        repeat ($urandom_range(TO - 2, 1)) @(posedge CLK);
        pulse(4'h2);
        repeat ($urandom_range(TO - 2, 1)) @(posedge CLK);
        pulse(4'h4);
        time_rst(TO);
        check(I2C_TIMER_RUN, 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            pulse(fst[i]);
            // A free edge keeps the two pulses from colliding
            if (snd[i] != 4'h0) begin
                @(posedge CLK);
                pulse(snd[i]);
            end
            time_rst(exq[i]);
        end
        $display("test i2c done");
        check(SPI_MISO_OE, 1'b0);
        for (int i = 0; i < 5; i++) begin
            tx = (i == 1) ? SPI_SYNC_BYTE : 8'($urandom) & 8'h7F;
            expq.push_back(tx);
            u_host.xfer(tx, rx);
            check(rx, (i == 3) ? SPI_ACK_BYTE : SPI_IDLE_BYTE);
            check(SPI_SYNCED, i > 0);
            check(SPI_MISO_OE, 1'b1);
        end
        check(expq.size(), 0);
        $display("test spi done");
        @(posedge CLK);
        USB_ATTACH <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            wait_conn(1'b1);
            check(XTAL_SEL, k);
            // A start-of-frame while detached must not lock
            if (k < 2) begin
                wait_conn(1'b0);
                @(posedge CLK);
                USB_SOF <= 1'b1;
                @(posedge CLK);
                USB_SOF <= 1'b0;
                #1;
                check(XTAL_LOCKED, 1'b0);
            end
        end
        @(posedge CLK);
        USB_SOF <= 1'b1;
        @(posedge CLK);
        USB_SOF <= 1'b0;
        repeat (60) @(posedge CLK);
        #1;
        check({USB_CONNECT, XTAL_LOCKED, XTAL_SEL}, {2'h3, XTAL_8M});
        @(posedge CLK);
        USB_ATTACH <= 1'b0;
        repeat (6) @(posedge CLK);
        #1;
        check(XTAL_LOCKED, 1'b0);
        $display("test usb done");
        end_of_test();
    end
endmodule
bind blltm_top blltm_properties #(
    .I2C_TIMEOUT (I2C_TIMEOUT)
) u_chk (
    .CLK             (CLK),
    .ARST_N          (ARST_N),
    .I2C_CMD_START   (I2C_CMD_START),
    .I2C_FRAME_START (I2C_FRAME_START),
    .I2C_BYTE_DONE   (I2C_BYTE_DONE),
    .I2C_TIMER_RUN   (I2C_TIMER_RUN),
    .SYS_RESET       (SYS_RESET),
    .SPI_RX_DATA     (SPI_RX_DATA),
    .SPI_RX_VALID    (SPI_RX_VALID),
    .SPI_SYNCED      (SPI_SYNCED),
    .USB_SOF         (USB_SOF),
    .USB_CONNECT     (USB_CONNECT),
    .XTAL_LOCKED     (XTAL_LOCKED)
);
